// [cfd_pkg.sv]
// How it works
// [RULE1] sustained over load trips channel after delay
// [RULE2] tripped channel stays off until flag cleared
// [RULE3] over temperature sets fault, switches channel off
// [RULE4] protection outcome latched in per-channel fault flag
// [RULE5] off channel latches open load after delay
// [RULE6] open-load flag kept apart from fault flag
// [RULE7] standby clears fault and open-load flags
// [RULE8] flags stay latched until standby is programmed
// [RULE9] no open-load detection while channel is on
// [RULE10] no open-load detection while in standby
// [RULE11] floating direct input reads low, channel off
// [RULE12] after reset all channels inactive, idle
// [RULE13] controller holds reset low at least 50 us
// [RULE14] device operational within 200 us after reset
// [RULE15] open-load delay lies within 30 to 200 us
// [RULE16] mode code 00 is standby, off, cleared
// [RULE17] over-load timer restarts when over current drops
package cfd_pkg;

   // ****************************************************************
   // sizes and clock
   // ****************************************************************
   localparam int CFD_CHANNELS = 8;
   localparam int CFD_DIRECT = 4;
   localparam int CFD_CLK_MHZ = 200; // cycles per microsecond

   // ****************************************************************
   // timing, in microseconds, and derived cycle counts
   // ****************************************************************
   localparam int CFD_OVL_MIN_US = 3;
   localparam int CFD_OVL_MAX_US = 50;
   localparam int CFD_OVL_DELAY_US = 10; // inside the allowed window
   localparam int CFD_OVL_CYCLES = CFD_OVL_DELAY_US * CFD_CLK_MHZ;
   localparam int CFD_OL_MIN_US = 30;
   localparam int CFD_OL_MAX_US = 200;
   localparam int CFD_OL_DELAY_US = 100; // inside the allowed window
   localparam int CFD_OL_CYCLES = CFD_OL_DELAY_US * CFD_CLK_MHZ;
   localparam int CFD_RESET_LOW_US = 50;
   localparam int CFD_WAKEUP_US = 200;
   localparam int CFD_WAKEUP_CYCLES = CFD_WAKEUP_US * CFD_CLK_MHZ;

   // ****************************************************************
   // channel mode codes, two bits per channel
   // ****************************************************************
   localparam int CFD_MODE_W = 2;
   typedef enum logic [CFD_MODE_W-1:0] {
      CFD_MODE_STANDBY = 2'h0,
      CFD_MODE_DIRECT = 2'h1,
      CFD_MODE_ON = 2'h2,
      CFD_MODE_OFF = 2'h3
   } cfd_mode_type;

   // ****************************************************************
   // latched diagnosis flags, one pair per channel
   // ****************************************************************
   typedef struct packed {
      logic [CFD_CHANNELS-1:0] channel_fault_flag;
      logic [CFD_CHANNELS-1:0] open_load_flag;
   } cfd_diag_type;

   // wake-up sequencing after reset
   typedef enum {CFD_WAKING, CFD_READY} cfd_wake_type;

endpackage

// [cfd_sync.sv]
`timescale 1ns/1ps
module cfd_sync
#(
   parameter int WIDTH = 1
)
(
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic [WIDTH-1:0] pin_i,
   output logic [WIDTH-1:0] level_o
);

   logic [WIDTH-1:0] s1_r;
   logic [WIDTH-1:0] s2_r;
   logic [WIDTH-1:0] s3_r;
   logic [WIDTH-1:0] level_r;
   logic [WIDTH-1:0] level_nxt;
   logic [WIDTH-1:0] differ;

   // a bit changes only once the second and third stage agree
   always_comb
   begin
      differ = s2_r ^ s3_r;
      level_nxt = (level_r & differ) | (s3_r & ~differ);
   end

   // three stage chain, cleared low so a floating pin reads low
   always_ff @(posedge sys_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
         level_r <= '0;
      end
      else
      begin
         s1_r <= pin_i;
         s2_r <= s1_r;
         s3_r <= s2_r;
         level_r <= level_nxt;
      end
   end

   assign level_o = level_r;

endmodule // cfd_sync

// [cfd_delay.sv]
`timescale 1ns/1ps
module cfd_delay
#(
   parameter int CYCLES = 2000
)
(
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic cond_i,
   output logic expired_o
);

   localparam int W = $clog2(CYCLES + 1);
   localparam logic [W-1:0] LAST = W'(CYCLES);
   localparam logic [W-1:0] STEP = W'(1);

   logic [W-1:0] count_r;
   logic [W-1:0] count_nxt;

   // counts while the condition holds, restarts as soon as it drops
   always_comb
   begin
      if (!cond_i)
         count_nxt = '0;
      else if (count_r == LAST)
         count_nxt = count_r;
      else
         count_nxt = count_r + STEP;
   end

   always_ff @(posedge sys_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         count_r <= '0;
      else
         count_r <= count_nxt;
   end

   // high once the condition has stood for CYCLES cycles
   assign expired_o = cond_i && (count_r == LAST);

endmodule // cfd_delay

// [cfd_top.sv]
`timescale 1ns/1ps
module cfd_top
#(
   parameter int OVL_CYCLES = cfd_pkg::CFD_OVL_CYCLES,
   parameter int OL_CYCLES = cfd_pkg::CFD_OL_CYCLES,
   parameter int WAKEUP_CYCLES = cfd_pkg::CFD_WAKEUP_CYCLES
)
(
   input wire logic sys_clk_i,
   input wire logic arst_n_i,
   input wire logic [2*cfd_pkg::CFD_CHANNELS-1:0] channel_mode_i,
   input wire logic [cfd_pkg::CFD_DIRECT-1:0] direct_channel_input_i,
   input wire logic limp_home_input_i,
   input wire logic [cfd_pkg::CFD_CHANNELS-1:0] overload_i,
   input wire logic [cfd_pkg::CFD_CHANNELS-1:0] overtemp_i,
   input wire logic [cfd_pkg::CFD_CHANNELS-1:0] output_low_i,
   output logic [cfd_pkg::CFD_CHANNELS-1:0] channel_on_o,
   output logic [cfd_pkg::CFD_CHANNELS-1:0] diag_current_en_o,
   output cfd_pkg::cfd_diag_type diag_o,
   output logic ready_o
);
   import cfd_pkg::*;

   localparam int NCH = CFD_CHANNELS;
   localparam int PINS = 3 * NCH + CFD_DIRECT + 1;
   localparam int RST_STAGES = 2; // reset release takes two of the cycles
   localparam int WW = $clog2(WAKEUP_CYCLES + 1);
   // ready exactly WAKEUP_CYCLES edges after the reset pin lets go
   localparam logic [WW-1:0] WAKE_LAST =
      WW'(WAKEUP_CYCLES - RST_STAGES - 1);
   localparam logic [WW-1:0] WAKE_STEP = WW'(1);

   // ****************************************************************
   // reset release
   // ****************************************************************
   logic rst_meta_r;
   logic rst_n_r;

   // reset pin enters asynchronously, leaves in step
   always_ff @(posedge sys_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         rst_meta_r <= 1'b0;
         rst_n_r <= 1'b0;
      end
      else
      begin
         rst_meta_r <= 1'b1;
         rst_n_r <= rst_meta_r;
      end
   end

   // ****************************************************************
   // pin inputs
   // ****************************************************************
   logic [PINS-1:0] pins_s;
   logic [NCH-1:0] ovl_s;
   logic [NCH-1:0] ot_s;
   logic [NCH-1:0] low_s;
   logic [CFD_DIRECT-1:0] dir_s;
   logic limp_s;

   // all analog indications and pins cross through one chain
   cfd_sync #(.WIDTH(PINS)) u_sync
   (
      .sys_clk_i(sys_clk_i),
      .rst_n_i(rst_n_r),
      .pin_i({limp_home_input_i, direct_channel_input_i,
              output_low_i, overtemp_i, overload_i}),
      .level_o(pins_s)
   );

   // unpack synchronised pins; open pins settle low
   assign ovl_s = pins_s[NCH-1:0];
   assign ot_s = pins_s[2*NCH-1:NCH];
   assign low_s = pins_s[3*NCH-1:2*NCH];
   assign dir_s = pins_s[3*NCH+CFD_DIRECT-1:3*NCH]; // RULE11
   assign limp_s = pins_s[PINS-1];

   // ****************************************************************
   // wake-up after reset
   // ****************************************************************
   cfd_wake_type wake_r;
   cfd_wake_type wake_nxt;
   logic [WW-1:0] wake_cnt_r;
   logic [WW-1:0] wake_cnt_nxt;
   logic ready;

   // channels are held inactive until the wake-up count runs out
   always_comb
   begin
      wake_nxt = wake_r;
      wake_cnt_nxt = wake_cnt_r;
      unique case (wake_r)
         CFD_WAKING:
         begin
            if (wake_cnt_r == WAKE_LAST)
               wake_nxt = CFD_READY; // RULE14
            else
               wake_cnt_nxt = wake_cnt_r + WAKE_STEP;
         end
         CFD_READY:
         begin
            wake_cnt_nxt = wake_cnt_r;
         end
      endcase
   end

   always_ff @(posedge sys_clk_i or negedge rst_n_r)
   begin
      if (!rst_n_r)
      begin
         wake_r <= CFD_WAKING;
         wake_cnt_r <= '0;
      end
      else
      begin
         wake_r <= wake_nxt;
         wake_cnt_r <= wake_cnt_nxt;
      end
   end

   assign ready = (wake_r == CFD_READY);
   assign ready_o = ready;

   // ****************************************************************
   // per-channel delay timers
   // ****************************************************************
   logic [NCH-1:0] ovl_cond;
   logic [NCH-1:0] ovl_exp;
   logic [NCH-1:0] ol_cond;
   logic [NCH-1:0] ol_exp;

   // one over-load and one open-load timer for every channel
   for (genvar g = 0; g < NCH; g++)
   begin : g_timer
      cfd_delay #(.CYCLES(OVL_CYCLES)) u_ovl
      (
         .sys_clk_i(sys_clk_i),
         .rst_n_i(rst_n_r),
         .cond_i(ovl_cond[g]),
         .expired_o(ovl_exp[g])
      );
      cfd_delay #(.CYCLES(OL_CYCLES)) u_ol
      (
         .sys_clk_i(sys_clk_i),
         .rst_n_i(rst_n_r),
         .cond_i(ol_cond[g]),
         .expired_o(ol_exp[g])
      );
   end

   // ****************************************************************
   // channel control and flags
   // ****************************************************************
   logic [NCH-1:0] on_r;
   logic [NCH-1:0] on_nxt;
   logic [NCH-1:0] fault_r;
   logic [NCH-1:0] fault_nxt;
   logic [NCH-1:0] ol_r;
   logic [NCH-1:0] ol_nxt;
   logic [NCH-1:0] diag_en_r;
   logic [NCH-1:0] diag_en_nxt;

   // mode field of one channel
   function automatic cfd_mode_type mode_of
   (
      input logic [2*CFD_CHANNELS-1:0] modes,
      input int ch
   );
      mode_of = cfd_mode_type'(modes[CFD_MODE_W*ch +: CFD_MODE_W]);
   endfunction

   // switching, protection and diagnosis for every channel
   always_comb
   begin
      cfd_mode_type m;
      logic dir;
      logic stb;
      logic req;
      logic trip;
      m = CFD_MODE_OFF;
      dir = 1'b0;
      stb = 1'b0;
      req = 1'b0;
      trip = 1'b0;
      for (int i = 0; i < NCH; i++)
      begin
         m = mode_of(channel_mode_i, i);
         dir = dir_s[i % CFD_DIRECT];
         stb = ready && !limp_s && (m == CFD_MODE_STANDBY); // RULE16
         // limp home hands the channel to its direct input
         if (limp_s)
            req = ready && dir;
         else
            req = ready && ((m == CFD_MODE_ON) ||
                            ((m == CFD_MODE_DIRECT) && dir));
         // timer runs only while on and over current stays
         ovl_cond[i] = on_r[i] && ovl_s[i]; // RULE17
         trip = ovl_exp[i] || ot_s[i]; // RULE1 RULE3
         // set wins over a clear in the same cycle
         fault_nxt[i] = (fault_r[i] && !stb) || (ready && trip); // RULE4 RULE7 RULE8
         // off state only, diagnosis disabled in standby and on
         ol_cond[i] = ready && !on_r[i] && !req && !stb && low_s[i]; // RULE5 RULE9 RULE10 RULE15
         ol_nxt[i] = (ol_r[i] && !stb) || ol_exp[i]; // RULE6 RULE7 RULE8
         // tripped channel stays off until its flag is cleared
         on_nxt[i] = req && !fault_r[i] && !trip; // RULE1 RULE2 RULE3
         diag_en_nxt[i] = ready && !stb && !on_nxt[i];
      end
   end

   // all channels off and flags clear until reset is gone
   always_ff @(posedge sys_clk_i or negedge rst_n_r)
   begin
      if (!rst_n_r)
      begin
         on_r <= '0; // RULE12
         fault_r <= '0;
         ol_r <= '0;
         diag_en_r <= '0;
      end
      else
      begin
         on_r <= on_nxt;
         fault_r <= fault_nxt;
         ol_r <= ol_nxt;
         diag_en_r <= diag_en_nxt;
      end
   end

   // ****************************************************************
   // outputs
   // ****************************************************************
   assign channel_on_o = on_r;
   assign diag_current_en_o = diag_en_r;
   assign diag_o.channel_fault_flag = fault_r;
   assign diag_o.open_load_flag = ol_r;

endmodule // cfd_top

// [cfd_load_model.sv]
`timescale 1ns/1ps
// ****************************************************************
// load on each output: short, overheating or disconnected
// ****************************************************************
module cfd_load_model
(
   input wire logic [7:0] channel_on_i,
   input wire logic [7:0] short_i,
   input wire logic [7:0] hot_i,
   input wire logic [7:0] open_i,
   output logic [7:0] overload_o,
   output logic [7:0] overtemp_o,
   output logic [7:0] output_low_o
);
   // over current flows only through a switched-on stage
   assign overload_o = short_i & channel_on_i;
   assign overtemp_o = hot_i;
   // a broken load shows low level whatever the stage does
   assign output_low_o = open_i;
endmodule // cfd_load_model

// [cfd_top_asserts.sv]
`timescale 1ns/1ps
module cfd_top_asserts
import cfd_pkg::*;
#(
   parameter int OVL_CYCLES = 8,
   parameter int OL_CYCLES = 16,
   parameter int WAKEUP_CYCLES = 10
)
(
   input wire logic sys_clk_i,
   input wire logic arst_n_i,
   input wire logic [15:0] channel_mode_i,
   input wire logic limp_home_input_i,
   input wire logic [7:0] channel_on_o,
   input wire logic [7:0] diag_current_en_o,
   input wire cfd_pkg::cfd_diag_type diag_o,
   input wire logic ready_o
);
   logic [7:0] stb_m;
   int wake_r;
   int wake_nxt;
   // standby mask and wake-up cycle count
   always_comb
   begin
      for (int i = 0; i < 8; i++)
         stb_m[i] = channel_mode_i[2*i +: 2] == CFD_MODE_STANDBY;
      wake_nxt = ready_o ? 0 : wake_r + 1;
   end
   always_ff @(posedge sys_clk_i or negedge arst_n_i)
      if (!arst_n_i) wake_r <= 0;
      else wake_r <= wake_nxt;
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!arst_n_i);
   property p_idle; !ready_o |-> channel_on_o == 8'h00; endproperty
   a_idle: assert property (p_idle) else $error("on before ready");
   property p_wake; wake_r <= WAKEUP_CYCLES; endproperty
   a_wake: assert property (p_wake) else $error("wake-up late");
   property p_no_on_fault; (channel_on_o & diag_o.channel_fault_flag) == 8'h00;
   endproperty
   a_no_on_fault: assert property (p_no_on_fault) else $error("on with fault");
   property p_ol_off; (diag_o.open_load_flag & ~$past(diag_o.open_load_flag)
      & $past(channel_on_o)) == 8'h00; endproperty
   a_ol_off: assert property (p_ol_off) else $error("open load while on");
   property p_fault_hold; (~diag_o.channel_fault_flag & ~$past(stb_m)
      & $past(diag_o.channel_fault_flag)) == 8'h00; endproperty
   a_fault_hold: assert property (p_fault_hold) else $error("fault lost");
   property p_ol_hold; (~diag_o.open_load_flag & ~$past(stb_m)
      & $past(diag_o.open_load_flag)) == 8'h00; endproperty
   a_ol_hold: assert property (p_ol_hold) else $error("open load lost");
   property p_stb_clr; $past(ready_o) && !$past(limp_home_input_i) |->
      (diag_o.open_load_flag & $past(stb_m)) == 8'h00; endproperty
   a_stb_clr: assert property (p_stb_clr) else $error("standby no clear");
   property p_stb_off; !$past(limp_home_input_i) |->
      ((channel_on_o | diag_current_en_o) & $past(stb_m)) == 8'h00; endproperty
   a_stb_off: assert property (p_stb_off) else $error("standby active");
   c_fault: cover property ($rose(diag_o.channel_fault_flag[0]));
   c_ol: cover property ($rose(diag_o.open_load_flag[1]));
   c_ready: cover property ($rose(ready_o));
endmodule // cfd_top_asserts

// [cfd_top_bench.sv]
`timescale 1ns/1ps
module cfd_top_bench;
import cfd_pkg::*;
   logic sys_clk_i = 1'b0;
   logic arst_n_i = 1'b0;
   logic [15:0] mode = 16'h0000;
   logic [3:0] dir = 4'h0;
   logic [7:0] short_v = 8'h00, hot_v = 8'h00, open_v = 8'h00, msk, e;
   logic [7:0] ovl, otmp, olow, on_v, dcur;
   cfd_diag_type diag;
   logic ready;
   logic limp = 1'b0;
   int failures = 0, num_checks = 0, seed = 14;
   // ****************************************************************
   // design, load and clock
   // ****************************************************************
   cfd_top #(.OVL_CYCLES(8), .OL_CYCLES(16), .WAKEUP_CYCLES(10)) i_dut
      (.sys_clk_i, .arst_n_i, .channel_mode_i(mode),
      .direct_channel_input_i(dir), .limp_home_input_i(limp),
      .overload_i(ovl), .overtemp_i(otmp), .output_low_i(olow),
      .channel_on_o(on_v), .diag_current_en_o(dcur), .diag_o(diag),
      .ready_o(ready));
   cfd_load_model i_load (.channel_on_i(on_v), .short_i(short_v),
      .hot_i(hot_v), .open_i(open_v), .overload_o(ovl),
      .overtemp_o(otmp), .output_low_o(olow));
   initial forever #2.5 sys_clk_i = ~sys_clk_i;
   // ****************************************************************
   // helpers
   // ****************************************************************
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         failures++;
         $display("CHECK FAILED %0t seen %h want %h", $time, seen, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge sys_clk_i);
   endtask
   task automatic wake;
      arst_n_i = 1'b1;
      for (int i = 0; i < 100 && ready !== 1'b1; i++) tick(1);
   endtask
   // expected switch state from modes, direct inputs and faults
   function automatic logic [7:0] exp_on(input logic [15:0] m,
      input logic [3:0] d, input logic [7:0] f);
      for (int i = 0; i < 8; i++)
         exp_on[i] = !f[i] && (m[2*i +: 2] == 2'h2
            || (m[2*i +: 2] == 2'h1 && d[i % 4]));
   endfunction
   task automatic results;
      if (failures == 0 && num_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // watchdog against a hang
   initial
   begin
      // the long reset hold alone takes about 10000 cycles
      #150000;
      failures++;
      results;
   end
   // ****************************************************************
   // scenarios
   // ****************************************************************
   initial
   begin
      tick(10);
      wake;
      check(on_v, 8'h00);
      check(diag[15:8], 8'h00);
      check(diag.open_load_flag, 8'h00);
      check({7'h00, ready}, 8'h01);
      repeat (8)
      begin
         mode = 16'($random(seed));
         dir = 4'($random(seed));
         tick(8);
         for (int i = 0; i < 8; i++)
         begin
            msk[i] = mode[2*i +: 2] == 2'h0 || mode[2*i +: 2] == 2'h3;
            e[i] = mode[2*i +: 2] == 2'h3;
         end
         check(on_v, exp_on(mode, dir, 8'h00));
         check(dcur & msk, e);
      end
      // short over load pulse, then a sustained one on channel 0
      mode = 16'hAAAA;
      tick(8);
      short_v = 8'h01;
      tick(6);
      short_v = 8'h00;
      tick(10);
      check(on_v, 8'hFF);
      short_v = 8'h01;
      tick(9);
      check(on_v, 8'hFF);
      tick(10);
      check(on_v, exp_on(mode, dir, 8'h01));
      check(diag.channel_fault_flag, 8'h01);
      short_v = 8'h00;
      tick(8);
      check(on_v, 8'hFE);
      mode = 16'hAAA8;
      tick(4);
      check(diag.channel_fault_flag, 8'h00);
      mode = 16'hAAAA;
      tick(4);
      check(on_v, 8'hFF);
      // over temperature on an on and an off channel
      mode = 16'hFFFB;
      hot_v = 8'h06;
      tick(8);
      check(on_v, 8'h00);
      hot_v = 8'h00;
      tick(8);
      check(diag.channel_fault_flag, 8'h06);
      check(diag.open_load_flag, 8'h00);
      mode = 16'h0000;
      tick(4);
      check(diag.channel_fault_flag, 8'h00);
      // open load in standby, off and on
      mode = 16'h002C;
      open_v = 8'h07;
      tick(12);
      check(diag.open_load_flag, 8'h00);
      tick(20);
      check(diag.open_load_flag, 8'h02);
      check(diag.open_load_flag & 8'h05, 8'h00);
      check(diag.channel_fault_flag, 8'h00);
      open_v = 8'h00;
      tick(8);
      check(diag.open_load_flag, 8'h02);
      mode = 16'h0000;
      tick(4);
      check(diag.open_load_flag, 8'h00);
      // all channels switched back on
      mode = 16'hAAAA;
      tick(6);
      // limp home: every channel follows its direct input
      limp = 1'b1;
      dir = 4'h5;
      tick(8);
      check(on_v, 8'h55);
      limp = 1'b0;
      tick(8);
      check(on_v, exp_on(mode, dir, 8'h00));
      // reset pulse held for the minimum low time
      arst_n_i = 1'b0;
      tick(CFD_RESET_LOW_US * CFD_CLK_MHZ);
      check(on_v, 8'h00);
      wake;
      tick(4);
      check(on_v, 8'hFF);
      results;
   end
endmodule // cfd_top_bench
bind cfd_top cfd_top_asserts #(.OVL_CYCLES(OVL_CYCLES),
   .OL_CYCLES(OL_CYCLES), .WAKEUP_CYCLES(WAKEUP_CYCLES)) i_chk
   (.sys_clk_i, .arst_n_i, .channel_mode_i, .limp_home_input_i,
   .channel_on_o, .diag_current_en_o, .diag_o, .ready_o);
